/* File: itpt_pkg.sv */
// itpt_pkg: constants, curve table, carrier and state types of the
// inverse time protection timer.
// assumes fixed point: times Q16.16 s, ratio Q16.16, alpha Q4.12,
// multiplier and dial Q8.8, timer level Q0.24 (unity = trip)
package itpt_pkg;

  // elaboration-time converters for the curve table
  function automatic logic [31:0] q16(real v);
    return 32'(longint'(v * 65536.0));
  endfunction
  function automatic logic [15:0] q12(real v);
    return 16'(longint'(v * 4096.0));
  endfunction

  localparam logic [31:0] ONE_Q16   = 32'h0001_0000; // 1.0 in Q16.16
  localparam logic [31:0] SAT32     = 32'hFFFF_FFFF; // saturated word
  localparam logic [63:0] ONE_Q32   = 64'h1_0000_0000; // 1.0 scaled for 1/x
  localparam logic [24:0] UNITY     = 25'h100_0000;  // full timer level
  localparam int          FRAC_W    = 16;            // Q16.16 fraction
  localparam int          ALPHA_SH  = 12;            // alpha fraction
  localparam int          MULT_SH   = 8;             // multiplier fraction
  localparam int          RATE_SH   = 40;            // Q16 time to Q24 rate
  localparam logic [63:0] US_PER_S  = 64'h0F_4240;   // microseconds per s
  localparam logic [6:0]  DIV_STEPS = 7'h40;         // quotient bits
  localparam logic [7:0]  LOG_BIAS  = 8'h10;         // integer bias of log2
  localparam logic signed [7:0] EXP_MAX = 8'sh0E;    // largest 2^n kept
  localparam logic signed [7:0] EXP_MIN = -8'sh11;   // below this 2^n = 0
  localparam logic [7:0]  DROP_NUM  = 8'h13;         // drop-off 19/20
  localparam logic [7:0]  DROP_DEN  = 8'h14;         // i.e. 95 percent
  localparam logic [31:0] RI_A      = q16(0.339);    // rapid inverse
  localparam logic [31:0] RI_B      = q16(0.236);    // rapid inverse

  // operate curve selection, code 4'hF is illegal and acts as definite
  typedef enum logic [3:0] {
    CRV_SI      = 4'h0, CRV_VI      = 4'h1, CRV_EI      = 4'h2,
    CRV_LTI     = 4'h3, CRV_RECT    = 4'h4, CRV_RI      = 4'h5,
    CRV_MI_NA   = 4'h6, CRV_VI_NA   = 4'h7, CRV_EI_NA   = 4'h8,
    CRV_US_INV  = 4'h9, CRV_US_ST   = 4'hA, CRV_ANSI_NI = 4'hB,
    CRV_ANSI_ST = 4'hC, CRV_ANSI_LT = 4'hD, CRV_DT      = 4'hE
  } itpt_curve_t;

  // per-curve constants; rs_ok = has inverse reset, na = dial family
  typedef struct packed {
    logic [31:0] op_b;
    logic [15:0] op_a;
    logic [31:0] op_l;
    logic [31:0] rs_b;
    logic [15:0] rs_a;
    logic        rs_ok;
    logic        na;
  } itpt_crv_t;

  localparam itpt_crv_t CRV_TAB [15] = '{
    '{q16(0.14), q12(0.02), q16(0.0), q16(8.2), q12(6.45), 1'b1, 1'b0},
    '{q16(13.5), q12(1.0), q16(0.0), q16(50.92), q12(2.4), 1'b1, 1'b0},
    '{q16(80.0), q12(2.0), q16(0.0), q16(44.1), q12(3.03), 1'b1, 1'b0},
    '{q16(120.0), q12(1.0), q16(0.0), q16(0.0), q12(0.0), 1'b0, 1'b0},
    '{q16(45900.0), q12(5.6), q16(0.0), q16(0.0), q12(0.0), 1'b0, 1'b0},
    '{q16(0.0), q12(0.0), q16(0.0), q16(0.0), q12(0.0), 1'b0, 1'b0},
    '{q16(0.0515), q12(0.02), q16(0.114), q16(4.85), q12(2.0), 1'b1, 1'b1},
    '{q16(19.61), q12(2.0), q16(0.491), q16(21.6), q12(2.0), 1'b1, 1'b1},
    '{q16(28.2), q12(2.0), q16(0.1217), q16(29.1), q12(2.0), 1'b1, 1'b1},
    '{q16(5.95), q12(2.0), q16(0.18), q16(5.95), q12(2.0), 1'b1, 1'b1},
    '{q16(0.16758), q12(0.02), q16(0.11858), q16(2.261), q12(2.0), 1'b1, 1'b1},
    '{q16(8.9341), q12(2.0938), q16(0.17966), q16(9.0), q12(2.0), 1'b1, 1'b1},
    '{q16(0.03393), q12(1.2969), q16(0.2663), q16(0.5), q12(2.0), 1'b1, 1'b1},
    '{q16(2.18592), q12(1.0), q16(5.6143), q16(15.75), q12(2.0), 1'b1, 1'b1},
    '{q16(0.0), q12(0.0), q16(0.0), q16(0.0), q12(0.0), 1'b0, 1'b0}
  };

  // stage settings, held stable by the scheme
  typedef struct packed {
    itpt_curve_t curve;    // operate curve
    logic        inv_rst;  // ask for inverse reset
    logic        under;    // undervalue function
    logic [15:0] tmult;    // time multiplier, Q8.8
    logic [15:0] dial;     // dial_setting_value, Q8.8
    logic [31:0] adder;    // definite adder, Q16.16 s
    logic [31:0] dt_dly;   // definite_delay, ticks
    logic [31:0] hold;     // stage_one_hold_time, ticks
  } itpt_set_t;

  // blocking inputs
  typedef struct packed {
    logic inhibit;    // function inhibit
    logic start_blk;  // start blocking
    logic timer_blk;  // timer block
  } itpt_blk_t;

  // computation sequence per tick
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h0, PH_M = 3'h1, PH_INV = 3'h2,
    PH_Q     = 3'h3, PH_RATE = 3'h4, PH_APPLY = 3'h5
  } itpt_phase_t;

  // whole block state
  typedef struct packed {
    itpt_phase_t ph;
    logic [6:0]  cnt;
    logic [63:0] num;
    logic [32:0] rem;
    logic [31:0] den;
    logic [31:0] m;
    logic [31:0] q;
    logic [31:0] rate;
    logic [24:0] acc;
    logic [31:0] dt_cnt;
    logic [31:0] hold_cnt;
    logic        picked;
    logic        st_s;
    logic        start;
    logic        trip;
    logic        hold_act;
  } itpt_state_t;

  localparam itpt_state_t ST_RST = '0;

endpackage

/* File: itpt_top.sv */
// itpt_top: one overcurrent stage, start level detector and
// inverse or definite timer producing trip.
// assumes inputs synchronous to clk_i, sample_tick_i a one-cycle
// pulse at least 300 clocks apart, settings held stable
`timescale 1ns/1ps
module itpt_top
#(
  parameter int          MEAS_W  = 16,     // measured value width
  parameter logic [63:0] TICK_US = 64'h3E8 // sample tick period, us
)
(
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 sample_tick_i,
  input  wire logic [MEAS_W-1:0]    meas_i,
  input  wire logic [MEAS_W-1:0]    thr_i,
  input  wire itpt_pkg::itpt_set_t  set_i,
  input  wire itpt_pkg::itpt_blk_t  blk_i,
  output wire logic                 start_o,
  output wire logic                 trip_o,
  output wire logic [24:0]          level_o,
  output wire logic                 hold_active_o
);

  // tick period scaled so that rate = TICK_NUM / t is Q0.24
  localparam logic [63:0] TICK_NUM = (TICK_US << itpt_pkg::RATE_SH) / itpt_pkg::US_PER_S;

  itpt_pkg::itpt_state_t s_r;        // registered state
  itpt_pkg::itpt_state_t s_nxt;      // next state
  logic [1:0]            rst_sync_r; // reset release pipeline
  logic                  rst_n;      // released reset

  itpt_pkg::itpt_curve_t crv_sel;    // curve, illegal code mapped
  itpt_pkg::itpt_crv_t   crv;        // constants of that curve
  logic [15:0]           mult;       // multiplier in use
  logic                  eff_irst;   // inverse reset in force
  logic                  is_dt;      // definite operate timer
  logic                  is_ri;      // rapid inverse curve
  logic [MEAS_W+4:0]     meas_x;     // meas scaled by 20
  logic [MEAS_W+4:0]     thr_x;      // thr scaled by 19
  logic [MEAS_W+4:0]     meas_y;     // meas scaled by 19
  logic [MEAS_W+4:0]     thr_y;      // thr scaled by 20
  logic                  pick;       // pickup condition
  logic                  drop;       // drop-off condition
  logic                  picked_nxt; // level detector next
  logic                  start_now;  // gated start
  logic [4:0]            msb;        // leading one of M
  logic [31:0]           norm;       // M normalised to bit 31
  logic signed [23:0]    lg;         // log2 M, Q8.16
  logic signed [40:0]    lgp;        // alpha times log2 M
  logic signed [23:0]    pw;         // exponent, Q8.16
  logic signed [7:0]     ip;         // integer part of exponent
  logic [16:0]           mant;       // 1.f mantissa
  logic [15:0]           alpha;      // alpha in use
  logic [31:0]           ma;         // M^alpha, Q16.16
  logic [63:0]           rib;        // 0.236 times 1/M
  logic [31:0]           den2;       // rapid inverse divisor
  logic [31:0]           d;          // curve divisor
  logic [31:0]           lterm;      // L term in use
  logic [31:0]           cterm;      // adder in use
  logic [49:0]           tsum;       // scaled time, wide
  logic [31:0]           t;          // time, Q16.16 s
  logic [32:0]           rem_sh;     // divider shifted remainder
  logic                  ge;         // divider subtract taken
  logic [32:0]           rem_dn;     // divider new remainder
  logic [63:0]           num_dn;     // divider new quotient
  logic [31:0]           quot;       // saturated quotient
  logic [32:0]           acc_sum;    // level plus rate

  // reset is asserted at once and released two clocks later
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // curve decode, family scaling and reset kind
  always_comb
  begin
    crv_sel  = (set_i.curve == itpt_pkg::itpt_curve_t'(4'hF)) ? itpt_pkg::CRV_DT : set_i.curve;
    crv      = itpt_pkg::CRV_TAB[crv_sel];
    is_dt    = (crv_sel == itpt_pkg::CRV_DT);
    is_ri    = (crv_sel == itpt_pkg::CRV_RI);
    mult     = crv.na ? set_i.dial : set_i.tmult;
    // rs_ok is clear for long time, rectifier, rapid and definite
    eff_irst = set_i.inv_rst & crv.rs_ok;
  end

  // level detector with drop-off hysteresis, then gating
  always_comb
  begin
    meas_x = (MEAS_W+5)'(meas_i) * (MEAS_W+5)'(itpt_pkg::DROP_DEN);
    thr_x  = (MEAS_W+5)'(thr_i) * (MEAS_W+5)'(itpt_pkg::DROP_NUM);
    meas_y = (MEAS_W+5)'(meas_i) * (MEAS_W+5)'(itpt_pkg::DROP_NUM);
    thr_y  = (MEAS_W+5)'(thr_i) * (MEAS_W+5)'(itpt_pkg::DROP_DEN);
    if (set_i.under)
    begin
      // undervalue: pick below threshold, drop above 20/19 of it
      pick = (meas_i < thr_i);
      drop = (meas_y > thr_y);
    end
    else
    begin
      pick = (meas_i > thr_i);
      drop = (meas_x < thr_x);
    end
    if (!s_r.picked)
      picked_nxt = pick;
    else
      picked_nxt = !drop;
    start_now = picked_nxt & !blk_i.inhibit & !blk_i.start_blk;
  end

  // M^alpha by log2/exp2 with linear mantissa; costs a few percent
  // of accuracy but needs no tables or multipliers beyond one
  always_comb
  begin
    msb = 5'h0;
    for (int i = 0; i < 32; i++)
    begin
      if (s_r.m[i])
        msb = 5'(i);
    end
    norm  = s_r.m << (5'h1F - msb);
    lg    = {8'({3'h0, msb}) - itpt_pkg::LOG_BIAS, norm[30:15]};
    alpha = s_r.st_s ? crv.op_a : crv.rs_a;
    lgp   = $signed({1'b0, alpha}) * lg;
    pw    = lgp[35:12];
    ip    = pw[23:16];
    mant  = {1'b1, pw[15:0]};
    if (s_r.m == 32'h0)
      ma = 32'h0; // no current at all
    else if (ip > itpt_pkg::EXP_MAX)
      ma = itpt_pkg::SAT32;
    else if (ip < itpt_pkg::EXP_MIN)
      ma = 32'h0;
    else if (ip >= 8'sh00)
      ma = 32'(mant) << 5'(ip);
    else
      ma = 32'(mant) >> 5'(-ip);
  end

  // divisor and time terms of the selected curve
  always_comb
  begin
    // q holds 1/M during the rapid inverse divisor step
    rib = 64'(itpt_pkg::RI_B) * 64'(s_r.q);
    if ((rib[63:48] == 16'h0) && (itpt_pkg::RI_A > rib[47:16]))
      den2 = itpt_pkg::RI_A - rib[47:16];
    else
      den2 = 32'h1; // below the asymptote: time grows without end
    if (is_ri)
      d = den2;
    else if (s_r.st_s)
      d = (ma > itpt_pkg::ONE_Q16) ? ma - itpt_pkg::ONE_Q16 : 32'h1;
    else
      d = (ma < itpt_pkg::ONE_Q16) ? itpt_pkg::ONE_Q16 - ma : 32'h1;
    lterm = s_r.st_s ? crv.op_l : 32'h0;
    cterm = s_r.st_s ? set_i.adder : 32'h0;
    tsum  = 50'((49'(mult) * (49'(s_r.q) + 49'(lterm))) >> itpt_pkg::MULT_SH) + 50'(cterm);
    t     = (tsum[49:32] != 18'h0) ? itpt_pkg::SAT32 : tsum[31:0];
  end

  // one restoring divider step per clock, shared by every quotient
  always_comb
  begin
    rem_sh = {s_r.rem[31:0], s_r.num[63]};
    ge     = (rem_sh >= {1'b0, s_r.den});
    rem_dn = ge ? rem_sh - {1'b0, s_r.den} : rem_sh;
    num_dn = {s_r.num[62:0], ge};
    quot   = (num_dn[63:32] != 32'h0) ? itpt_pkg::SAT32 : num_dn[31:0];
  end

  // sequence, timer update and outputs
  always_comb
  begin
    s_nxt        = s_r;
    acc_sum      = 33'(s_r.acc) + 33'(s_r.rate);
    s_nxt.picked = picked_nxt;
    s_nxt.start  = start_now;
    unique case (s_r.ph)
      itpt_pkg::PH_IDLE:
      begin
        // tick: freeze direction, compute only when it matters
        if (sample_tick_i)
        begin
          s_nxt.st_s = s_r.start;
          s_nxt.cnt  = 7'h0;
          if ((s_r.start && !is_dt) || (!s_r.start && eff_irst && (s_r.acc != 25'h0)))
            s_nxt.ph = itpt_pkg::PH_M;
          else
            s_nxt.ph = itpt_pkg::PH_APPLY;
        end
      end
      itpt_pkg::PH_M, itpt_pkg::PH_INV, itpt_pkg::PH_Q, itpt_pkg::PH_RATE:
      begin
        if (s_r.cnt == 7'h0)
        begin
          // load operands of this quotient
          s_nxt.rem = 33'h0;
          s_nxt.cnt = 7'h1;
          if (s_r.ph == itpt_pkg::PH_M)
          begin
            s_nxt.num = 64'(meas_i) << itpt_pkg::FRAC_W;
            s_nxt.den = 32'(thr_i);
          end
          else if (s_r.ph == itpt_pkg::PH_INV)
          begin
            s_nxt.num = 64'(thr_i) << itpt_pkg::FRAC_W;
            s_nxt.den = 32'(meas_i);
          end
          else if (s_r.ph == itpt_pkg::PH_Q)
          begin
            if (is_ri)
              s_nxt.num = itpt_pkg::ONE_Q32;
            else if (s_r.st_s)
              s_nxt.num = 64'(crv.op_b) << itpt_pkg::FRAC_W;
            else
              s_nxt.num = 64'(crv.rs_b) << itpt_pkg::FRAC_W;
            s_nxt.den = d;
          end
          else
          begin
            s_nxt.num = TICK_NUM;
            s_nxt.den = t;
          end
        end
        else
        begin
          s_nxt.num = num_dn;
          s_nxt.rem = rem_dn;
          s_nxt.cnt = s_r.cnt + 7'h1;
          if (s_r.cnt == itpt_pkg::DIV_STEPS)
          begin
            s_nxt.cnt = 7'h0;
            if (s_r.ph == itpt_pkg::PH_M)
            begin
              s_nxt.m  = quot;
              s_nxt.ph = (s_r.st_s && is_ri) ? itpt_pkg::PH_INV : itpt_pkg::PH_Q;
            end
            else if (s_r.ph == itpt_pkg::PH_INV)
            begin
              s_nxt.q  = quot;
              s_nxt.ph = itpt_pkg::PH_Q;
            end
            else if (s_r.ph == itpt_pkg::PH_Q)
            begin
              s_nxt.q  = quot;
              s_nxt.ph = itpt_pkg::PH_RATE;
            end
            else
            begin
              s_nxt.rate = quot;
              s_nxt.ph   = itpt_pkg::PH_APPLY;
            end
          end
        end
      end
      itpt_pkg::PH_APPLY:
      begin
        s_nxt.ph = itpt_pkg::PH_IDLE;
        if (s_r.st_s)
        begin
          // started: a pending hold is cancelled, timing goes on
          s_nxt.hold_cnt = 32'h0;
          s_nxt.hold_act = 1'b0;
          if (!blk_i.timer_blk)
          begin
            if (is_dt)
            begin
              if (s_r.dt_cnt < set_i.dt_dly)
                s_nxt.dt_cnt = s_r.dt_cnt + 32'h1;
            end
            else if (acc_sum >= 33'(itpt_pkg::UNITY))
              s_nxt.acc = itpt_pkg::UNITY;
            else
              s_nxt.acc = acc_sum[24:0];
          end
        end
        else if (eff_irst)
        begin
          // inverse reset decays; hold setting plays no part
          if (32'(s_r.acc) > s_r.rate)
            s_nxt.acc = s_r.acc - s_r.rate[24:0];
          else
            s_nxt.acc = 25'h0;
        end
        else if (set_i.hold == 32'h0)
        begin
          // instant reset once the detector has dropped off
          s_nxt.acc    = 25'h0;
          s_nxt.dt_cnt = 32'h0;
        end
        else if ((s_r.acc != 25'h0) || (s_r.dt_cnt != 32'h0))
        begin
          // hold keeps the level so repeated pulses integrate
          if (s_r.hold_cnt + 32'h1 >= set_i.hold)
          begin
            s_nxt.acc      = 25'h0;
            s_nxt.dt_cnt   = 32'h0;
            s_nxt.hold_cnt = 32'h0;
            s_nxt.hold_act = 1'b0;
          end
          else
          begin
            s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
            s_nxt.hold_act = 1'b1;
          end
        end
      end
      default:
      begin
        s_nxt.ph = itpt_pkg::PH_IDLE; // unused phase codes recover
      end
    endcase
    if (eff_irst || (set_i.hold == 32'h0)) // no hold flag left over once hold cannot apply
      s_nxt.hold_act = 1'b0;
    // trip follows start at once so dropout clears it immediately
    if (is_dt)
      s_nxt.trip = start_now & !blk_i.timer_blk & (s_nxt.dt_cnt >= set_i.dt_dly);
    else
      s_nxt.trip = start_now & !blk_i.timer_blk & (s_nxt.acc >= itpt_pkg::UNITY);
  end

  // single state register
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= itpt_pkg::ST_RST;
    else
      s_r <= s_nxt;
  end

  assign start_o       = s_r.start;
  assign trip_o        = s_r.trip;
  assign level_o       = s_r.acc;
  assign hold_active_o = s_r.hold_act;

endmodule

/* File: itpt_top_monitor.sv */
// itpt_top_monitor: concurrent checks on the ports of one stage timer.
// assumes bound into itpt_top; one clock domain, async active-low reset.
`timescale 1ns/1ps
module itpt_top_monitor
#(
  parameter int          MEAS_W  = 16,     // measured value width
  parameter logic [63:0] TICK_US = 64'h3E8 // tick period, us
)
(
  input wire logic                clk_i,
  input wire logic                reset_n_i,
  input wire logic                sample_tick_i,
  input wire logic [MEAS_W-1:0]   meas_i,
  input wire logic [MEAS_W-1:0]   thr_i,
  input wire itpt_pkg::itpt_set_t set_i,
  input wire itpt_pkg::itpt_blk_t blk_i,
  input wire logic                start_o,
  input wire logic                trip_o,
  input wire logic [24:0]         level_o,
  input wire logic                hold_active_o
);
  logic [1:0]  up_r;   // edges since release, stage live at 2'h3
  logic [8:0]  age_r;  // clocks since last tick, saturating
  logic [31:0] m20;    // twenty times the measurement
  logic [31:0] t19;    // nineteen times the threshold
  logic        inv_rs; // an inverse reset is in force
  assign m20 = 32'(meas_i) * 32'h14;
  assign t19 = 32'(thr_i) * 32'h13;
  assign inv_rs = set_i.inv_rst && (set_i.curve <= itpt_pkg::CRV_EI ||
    (set_i.curve >= itpt_pkg::CRV_MI_NA && set_i.curve <= itpt_pkg::CRV_ANSI_LT));
  // helper counters; age starts saturated since nothing moves before a tick
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      up_r  <= 2'h0;
      age_r <= 9'h1FF;
    end
    else
    begin
      up_r  <= {up_r[0], 1'b1};
      age_r <= sample_tick_i ? 9'h000 : age_r + {8'h00, age_r != 9'h1FF};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // blocking condition and unblocked pickup conditions
  sequence blocked_s;
    blk_i.inhibit || blk_i.start_blk;
  endsequence
  sequence over_s;
    up_r[1] && !set_i.under && meas_i > thr_i && !blk_i.inhibit && !blk_i.start_blk;
  endsequence
  sequence under_s;
    up_r[1] && set_i.under && meas_i < thr_i && !blk_i.inhibit && !blk_i.start_blk;
  endsequence
  start_blocked_a : assert property (blocked_s |=> !start_o)
    else $error("start seen while blocked");
  over_pick_a : assert property (over_s |=> start_o)
    else $error("no start above threshold");
  under_pick_a : assert property (under_s |=> start_o)
    else $error("no start below threshold");
  drop_off_a : assert property (up_r[1] && !set_i.under && m20 < t19 |=> !start_o)
    else $error("start held below drop-off");
  trip_start_a : assert property (trip_o |-> start_o || $past(start_o))
    else $error("trip without start");
  timer_block_a : assert property (blk_i.timer_blk |=> !trip_o)
    else $error("trip while timer blocked");
  inv_trip_a : assert property ($rose(trip_o) && set_i.curve < itpt_pkg::CRV_DT |->
    level_o == itpt_pkg::UNITY) else $error("inverse trip below unity");
  level_cap_a : assert property (level_o <= itpt_pkg::UNITY)
    else $error("level above unity");
  level_tick_a : assert property ($changed(level_o) |-> age_r < 9'h12C)
    else $error("level moved away from a tick");
  hold_zero_a : assert property (hold_active_o |-> set_i.hold != 32'h0)
    else $error("hold active with zero hold");
  hold_inv_a : assert property (inv_rs |=> !hold_active_o)
    else $error("hold active under inverse reset");
endmodule
bind itpt_top itpt_top_monitor #(.MEAS_W(MEAS_W), .TICK_US(TICK_US)) u_mon
(
  .clk_i(clk_i), .reset_n_i(reset_n_i), .sample_tick_i(sample_tick_i), .meas_i(meas_i),
  .thr_i(thr_i), .set_i(set_i), .blk_i(blk_i), .start_o(start_o), .trip_o(trip_o),
  .level_o(level_o), .hold_active_o(hold_active_o)
);

/* File: itpt_front_model.sv */
// itpt_front_model: measurement front end, issues the sample tick.
// assumes one clock; the period must exceed the stage's longest computation.
`timescale 1ns/1ps
module itpt_front_model
#(
  parameter int PERIOD = 400 // clocks between ticks
)
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  output logic      tick_o
);
  int cnt_r; // clocks since the last tick
  // one-cycle tick; quiet in reset so the stage sees none too early
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_r  <= 0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_r  <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      tick_o <= (cnt_r == PERIOD - 1);
    end
  end
endmodule

/* File: itpt_testbench.sv */
// testbench: level detector, definite and inverse timers, hold and reset.
// assumes itpt_top with a 1000 us tick, ticks from itpt_front_model.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
  localparam real TS = 0.001;      // tick period, s
  localparam real U  = 16777216.0; // unity level
  logic                clk;
  logic                reset_n = 1'b0;
  logic                tick;
  logic                start;
  logic                trip;
  logic                hact;
  logic [15:0]         meas;
  logic [15:0]         thr;
  logic [24:0]         level;
  logic [24:0]         prev;
  itpt_pkg::itpt_set_t set_r;
  itpt_pkg::itpt_blk_t blk_r;
  int                  fails = 0;
  int                  samples_checked = 0;
  itpt_front_model u_front (.clk_i(clk), .reset_n_i(reset_n), .tick_o(tick));
  itpt_top #(.MEAS_W(16), .TICK_US(64'h3E8)) dut
  (
    .clk_i(clk), .reset_n_i(reset_n), .sample_tick_i(tick), .meas_i(meas), .thr_i(thr),
    .set_i(set_r), .blk_i(blk_r), .start_o(start), .trip_o(trip), .level_o(level),
    .hold_active_o(hact)
  );
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // settle past n edges before looking
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // wait n ticks, each one's computation finished
  task automatic ticks(int n);
    repeat (n)
    begin
      @(posedge clk iff tick);
      repeat (270) @(posedge clk);
    end
    #1;
  endtask
  // new measurement at the next edge
  task automatic drive(logic [15:0] m);
    @(posedge clk);
    meas <= m;
    step(2);
  endtask
  // the timer works approximately, so expect within 15 percent
  function automatic logic band(logic [24:0] v, real e);
    return (v >= e * 0.85) && (v <= e * 1.15);
  endfunction
  task automatic end_of_test;
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog, about two and a half times the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end
  initial
  begin
    meas = 16'h0000;
    thr = 16'h0064;
    set_r = '0;
    set_r.curve = itpt_pkg::CRV_DT;
    set_r.dt_dly = 32'h2;
    blk_r = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    step(3);
    `CHK("start", 1'b0, start)
    `CHK("level", 25'h0, level)
    drive(16'h0064); // equal is not above
    `CHK("start", 1'b0, start)
    drive(16'h0065);
    `CHK("start", 1'b1, start)
    drive(16'h0060); // inside drop-off band
    `CHK("start", 1'b1, start)
    ticks(1);
    `CHK("trip", 1'b0, trip)
    ticks(1);
    `CHK("trip", 1'b1, trip)
    @(posedge clk);
    blk_r.timer_blk <= 1'b1;
    step(2);
    `CHK("trip", 1'b0, trip)
    @(posedge clk);
    blk_r.timer_blk <= 1'b0;
    blk_r.inhibit <= 1'b1;
    step(2);
    `CHK("start", 1'b0, start)
    @(posedge clk);
    blk_r.inhibit <= 1'b0;
    drive(16'h005E); // below drop-off band
    `CHK("start", 1'b0, start)
    ticks(1);
    drive(16'h0065);
    ticks(1);
    `CHK("trip", 1'b0, trip)
    @(posedge clk);
    set_r.under <= 1'b1;
    drive(16'h0063);
    `CHK("start", 1'b1, start)
    drive(16'h0078);
    `CHK("start", 1'b0, start)
    drive(16'h0063); // fresh pickup below threshold
    `CHK("start", 1'b1, start)
    @(posedge clk);
    set_r.under <= 1'b0;
    set_r.curve <= itpt_pkg::CRV_VI;
    set_r.tmult <= 16'h0001;
    set_r.hold <= 32'h2;
    meas <= 16'h03E8; // ten times threshold
    ticks(1);
    `CHK("level", 1'b1, band(level, U * TS / (13.5 / 9.0 / 256.0)))
    ticks(4);
    `CHK("trip", 1'b0, trip)
    ticks(2);
    `CHK("trip", 1'b1, trip)
    `CHK("level", itpt_pkg::UNITY, level)
    drive(16'h0000);
    ticks(1);
    `CHK("hold", 1'b1, hact)
    `CHK("level", itpt_pkg::UNITY, level)
    ticks(2);
    `CHK("level", 25'h0, level)
    @(posedge clk);
    set_r.curve <= itpt_pkg::CRV_VI_NA;
    set_r.tmult <= 16'hFFFF; // must be ignored by the dial family
    set_r.dial <= 16'h0001;
    set_r.adder <= 32'h42;
    meas <= 16'h03E8;
    ticks(1);
    `CHK("level", 1'b1, band(level, U * TS / ((19.61 / 99.0 + 0.491) / 256.0 + 66.0 / 65536.0)))
    prev = level;
    @(posedge clk);
    set_r.inv_rst <= 1'b1;
    meas <= 16'h0032; // half the threshold
    ticks(1);
    `CHK("hold", 1'b0, hact)
    `CHK("decay", 1'b1, band(prev - level, U * TS / (21.6 / 0.75 / 256.0)))
    @(posedge clk);
    set_r.curve <= itpt_pkg::CRV_LTI;
    set_r.hold <= 32'h0;
    set_r.adder <= 32'h0;
    set_r.tmult <= 16'h0001;
    ticks(1);
    `CHK("level", 25'h0, level)
    drive(16'h03E8);
    ticks(1);
    `CHK("level", 1'b1, band(level, U * TS / (120.0 / 9.0 / 256.0)))
    prev = level;
    @(posedge clk);
    set_r.curve <= itpt_pkg::CRV_RI;
    ticks(1);
    `CHK("level", 1'b1, band(level - prev, U * TS / (1.0 / (0.339 - 0.236 / 10.0) / 256.0)))
    drive(16'h0000); // inverse reset still asked for, must be ignored
    ticks(1);
    `CHK("level", 25'h0, level)
    end_of_test;
  end
endmodule
